// [verilog/ivp_top.sv]
// Interrupt vector placement: control register, timed change window,
// interrupt blocking and vector/reset address generation.
// Assumes APB from the core, fuse and lock levels stable, and a one-cycle
// instruction retire pulse from the core.
`timescale 1ns/100ps
`default_nettype none
module ivp_top #(
  parameter logic [11:0] BOOT_START_1 = 12'hE00,
  parameter logic [11:0] BOOT_START_2 = 12'hF00,
  parameter logic [11:0] BOOT_START_3 = 12'hF80
) (
  input  wire logic        CLK_I,
  input  wire logic        SRST_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [11:0] PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  input  wire logic [3:0]  PSTRB_I,
  output logic [31:0]      PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  input  wire logic [1:0]  BOOT_SIZE_FUSES_I,
  input  wire logic        BOOT_RESET_PROG_I,
  input  wire logic        APP_LOCK_PROG_I,
  input  wire logic        BOOT_LOCK_PROG_I,
  input  wire logic [11:0] PC_I,
  input  wire logic        INSN_RETIRE_I,
  input  wire logic        GIE_I,
  input  wire logic [4:0]  IRQ_NUM_I,
  output logic [11:0]      VECTOR_BASE_O,
  output logic [11:0]      VECTOR_ADDR_O,
  output logic [11:0]      RESET_ADDR_O,
  output logic [2:0]       SPARE_CTRL_O,
  output logic             IRQ_BLOCK_O,
  output logic             IRQ_ENABLE_O
);

  logic                     hit;
  logic                     wr_taken;
  logic                     ce_write;
  logic                     sel_write;
  logic                     base_select;
  logic [ivp_pkg::SPARE_W-1:0] spare;
  logic [ivp_pkg::WINDOW_W-1:0] win_count;
  logic                     win_active;
  logic                     post_hold;
  logic                     seq_block;
  logic                     lock_block;
  logic                     in_boot;
  logic [11:0]              boot_start;
  logic [7:0]               reg_value;
  logic [11:0]              next_vector_addr;
  ivp_pkg::ivp_seq_t        seq_state;

  assign hit      = (PADDR_I == ivp_pkg::MCU_CONTROL_OFFSET);
  // The register lives in byte lane 0, so only that strobe commits a write.
  assign wr_taken = PSEL_I && PENABLE_I && PWRITE_I && hit && PSTRB_I[0];
  assign ce_write = wr_taken && PWDATA_I[ivp_pkg::CHANGE_ENABLE_BIT];
  assign sel_write = wr_taken && !PWDATA_I[ivp_pkg::CHANGE_ENABLE_BIT] && win_active;

  assign PREADY_O  = 1'b1;
  assign PSLVERR_O = PSEL_I && PENABLE_I && !hit;

  // Boot section start from the fuse code; only the 2K code is fixed.
  always_comb begin
    unique case (BOOT_SIZE_FUSES_I)
      ivp_pkg::BOOT_SIZE_2K: boot_start = ivp_pkg::BOOT_START_2K;
      2'h1:                  boot_start = BOOT_START_1;
      2'h2:                  boot_start = BOOT_START_2;
      2'h3:                  boot_start = BOOT_START_3;
    endcase
  end

  ivp_window_timer #(
    .CNT_W (ivp_pkg::WINDOW_W),
    .LOAD  (ivp_pkg::WINDOW_LOAD)
  ) u_window (
    .clk_i    (CLK_I),
    .srst_i   (SRST_I),
    .load_i   (ce_write),
    .clear_i  (sel_write),
    .count_o  (win_count),
    .active_o (win_active)
  );

  // A select write in an open window is the only path that changes placement.
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      base_select <= ivp_pkg::MCU_CONTROL_RESET[ivp_pkg::BASE_SELECT_BIT];
    end else if (sel_write) begin
      base_select <= PWDATA_I[ivp_pkg::BASE_SELECT_BIT];
    end
  end

  // The remaining low bits are plain storage handed to neighbouring logic.
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      spare <= ivp_pkg::MCU_CONTROL_RESET[ivp_pkg::SPARE_HI_BIT:ivp_pkg::SPARE_LO_BIT];
    end else if (wr_taken) begin
      spare <= PWDATA_I[ivp_pkg::SPARE_HI_BIT:ivp_pkg::SPARE_LO_BIT];
    end
  end

  // After the select write the block persists until one more instruction retires.
  // A retire in the write cycle itself belongs to the writing instruction.
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      post_hold <= 1'b0;
    end else if (sel_write) begin
      post_hold <= 1'b1;
    end else if (ce_write) begin
      post_hold <= 1'b0;
    end else if (INSN_RETIRE_I) begin
      post_hold <= 1'b0;
    end
  end

  // The sequence state mirrors the timer and hold flag for the checks below; it drives no output.
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      seq_state <= ivp_pkg::IVP_IDLE;
    end else if (ce_write) begin
      seq_state <= ivp_pkg::IVP_WINDOW;
    end else if (sel_write) begin
      seq_state <= ivp_pkg::IVP_HOLD;
    end else begin
      unique case (seq_state)
        ivp_pkg::IVP_IDLE:   seq_state <= ivp_pkg::IVP_IDLE;
        ivp_pkg::IVP_WINDOW: begin
          if (win_count == ivp_pkg::WINDOW_W'(1)) begin
            seq_state <= ivp_pkg::IVP_IDLE;
          end
        end
        ivp_pkg::IVP_HOLD:   begin
          if (INSN_RETIRE_I) begin
            seq_state <= ivp_pkg::IVP_IDLE;
          end
        end
      endcase
    end
  end

  // The enable write cycle itself is already blocked.
  assign seq_block = ce_write || win_active || post_hold;

  // Everything from the boot start word upward counts as the boot section.
  assign in_boot    = (PC_I >= boot_start);
  assign lock_block = (base_select && APP_LOCK_PROG_I && !in_boot)
                   || (!base_select && BOOT_LOCK_PROG_I && in_boot);

  assign IRQ_BLOCK_O = seq_block || lock_block;
  // The core's global flag is only gated here, never written back.
  assign IRQ_ENABLE_O = GIE_I && !IRQ_BLOCK_O;

  assign VECTOR_BASE_O = base_select ? boot_start : ivp_pkg::APP_START;
  assign RESET_ADDR_O  = BOOT_RESET_PROG_I ? boot_start : ivp_pkg::APP_START;
  assign SPARE_CTRL_O  = spare;

  assign next_vector_addr = VECTOR_BASE_O + {7'h00, IRQ_NUM_I};

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      VECTOR_ADDR_O <= ivp_pkg::APP_START;
    end else begin
      VECTOR_ADDR_O <= next_vector_addr;
    end
  end

  assign reg_value = {3'h0, spare, base_select, win_active};

  // Read data is captured in the setup phase so the access phase needs no wait.
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      PRDATA_O <= 32'h0000_0000;
    end else if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
      PRDATA_O <= hit ? {24'h00_0000, reg_value} : 32'h0000_0000;
    end
  end

  window_load_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
    ce_write |=> (win_count == 3'h4))
    else $error("window not loaded with four cycles");

  window_count_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
    (win_active && !wr_taken) |=> (win_count == $past(win_count) - 3'h1))
    else $error("window count did not step down");

  select_locked_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
    (wr_taken && !win_active) |=> (base_select == $past(base_select)))
    else $error("select changed outside window");

  select_update_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
    sel_write |=> (base_select == $past(PWDATA_I[1])) && !win_active)
    else $error("select write in window not applied");

  block_set_cycle_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
    ce_write |-> IRQ_BLOCK_O ##1 IRQ_BLOCK_O)
    else $error("interrupts not blocked at enable");

  block_hold_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
    ((sel_write || (post_hold && !INSN_RETIRE_I)) && !ce_write) |=> IRQ_BLOCK_O)
    else $error("block lifted before next instruction");

  block_release_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
    (win_count == 3'h1 && !wr_taken && !post_hold) ##1 !wr_taken |-> !seq_block)
    else $error("block did not lift after four cycles");

  gie_gate_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
    IRQ_ENABLE_O == (GIE_I && !IRQ_BLOCK_O))
    else $error("global flag gating wrong");

  base_place_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
    VECTOR_BASE_O == (base_select ? boot_start : 12'h000))
    else $error("vector base wrong");

  app_lock_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
    (base_select && APP_LOCK_PROG_I && PC_I < boot_start) |-> !IRQ_ENABLE_O)
    else $error("application lock did not block");

  boot_lock_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
    (!base_select && BOOT_LOCK_PROG_I && PC_I >= boot_start) |-> !IRQ_ENABLE_O)
    else $error("boot lock did not block");

  reset_addr_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
    (BOOT_RESET_PROG_I && BOOT_SIZE_FUSES_I == 2'h0) |-> RESET_ADDR_O == 12'hC00)
    else $error("boot reset address wrong");

  vector_addr_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
    (base_select && BOOT_SIZE_FUSES_I == 2'h0 && IRQ_NUM_I == 5'h1F)
      |=> VECTOR_ADDR_O == 12'hC1F)
    else $error("last relocated vector address wrong");

  // The sequence state, stepped by the window count, must agree with the window and the hold flag.
  seq_state_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
    (seq_state != ivp_pkg::IVP_IDLE) == (win_active || post_hold))
    else $error("sequence state disagrees with window and hold");

  block_clear_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
    (post_hold && INSN_RETIRE_I) |=> !post_hold)
    else $error("hold not released by retire");

  window_close_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
    (win_count == 3'h1 && !ce_write) |=> !win_active)
    else $error("window stayed open past four cycles");

  block_window_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
    win_active |-> (IRQ_BLOCK_O && !IRQ_ENABLE_O))
    else $error("interrupts not blocked in window");

  select_steady_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
    !wr_taken |=> (base_select == $past(base_select)))
    else $error("select changed without a write");

  // Bus side: lane 0 qualifies every write, and read data come from the setup cycle.
  strobe_guard_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
    (PSEL_I && PENABLE_I && PWRITE_I && !PSTRB_I[0])
      |=> (base_select == $past(base_select)) && (spare == $past(spare)))
    else $error("write without lane zero changed register");

  spare_write_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
    wr_taken |=> (SPARE_CTRL_O ==
      $past(PWDATA_I[ivp_pkg::SPARE_HI_BIT:ivp_pkg::SPARE_LO_BIT])))
    else $error("spare bits not written");

  prdata_capture_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
    (PSEL_I && !PENABLE_I && !PWRITE_I && hit)
      |=> (PRDATA_O == {24'h00_0000, $past(reg_value)}))
    else $error("read data not captured in setup");

  slave_answer_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
    (PSEL_I && PENABLE_I && hit) |-> (PREADY_O && !PSLVERR_O))
    else $error("mapped access not answered cleanly");

  // Address generation for the fixed 2K boot section and the application reset address.
  boot_base_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
    (base_select && BOOT_SIZE_FUSES_I == 2'h0) |-> (VECTOR_BASE_O == 12'hC00))
    else $error("relocated base wrong for 2K section");

  reset_app_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
    !BOOT_RESET_PROG_I |-> (RESET_ADDR_O == 12'h000))
    else $error("application reset address wrong");

  first_vector_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
    (base_select && BOOT_SIZE_FUSES_I == 2'h0 && IRQ_NUM_I == 5'h01)
      |=> VECTOR_ADDR_O == 12'hC01)
    else $error("first relocated vector address wrong");

endmodule : ivp_top
`default_nettype wire

// [verilog/ivp_pkg.sv]
// Constants shared by the interrupt vector placement block.
// Assumes a 32-bit APB slave port and 12-bit program word addresses.
package ivp_pkg;

  localparam int           ADDR_W              = 12;
  localparam int           PC_W                = 12;
  localparam int           IRQ_NUM_W           = 5;

  // The control register sits alone in the slave's address range.
  localparam logic [11:0]  MCU_CONTROL_OFFSET  = 12'h000;
  localparam logic [7:0]   MCU_CONTROL_RESET   = 8'h00;

  // Bit positions in the control register.
  localparam int           CHANGE_ENABLE_BIT   = 0;
  localparam int           BASE_SELECT_BIT     = 1;
  localparam int           SPARE_LO_BIT        = 2;
  localparam int           SPARE_HI_BIT        = 4;
  localparam int           SPARE_W             = 3;

  // Length of the change window, in core clock cycles.
  localparam int           WINDOW_CYCLES       = 4;
  localparam int           WINDOW_W            = 3;
  localparam logic [2:0]   WINDOW_LOAD         = 3'h4;

  // Fuse code and start word address of the fixed 2K boot section, and the application start.
  localparam logic [1:0]   BOOT_SIZE_2K        = 2'h0;
  localparam logic [11:0]  BOOT_START_2K       = 12'hC00;
  localparam logic [11:0]  APP_START           = 12'h000;

  typedef enum logic [1:0] {
    IVP_IDLE,
    IVP_WINDOW,
    IVP_HOLD
  } ivp_seq_t;

endpackage : ivp_pkg

// [verilog/ivp_window_timer.sv]
// Down counter that holds the change window open for a fixed count.
// Assumes load and clear are single-cycle pulses on the core clock.
`timescale 1ns/100ps
`default_nettype none
module ivp_window_timer #(
  parameter int         CNT_W = 3,
  parameter logic [2:0] LOAD  = 3'h4
) (
  input  wire logic             clk_i,
  input  wire logic             srst_i,
  input  wire logic             load_i,
  input  wire logic             clear_i,
  output logic [CNT_W-1:0]      count_o,
  output logic                  active_o
);

  // A reload while open restarts the full count.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      count_o <= '0;
    end else if (load_i) begin
      count_o <= CNT_W'(LOAD);
    end else if (clear_i) begin
      count_o <= '0;
    end else if (count_o != '0) begin
      count_o <= count_o - CNT_W'(1);
    end
  end

  assign active_o = (count_o != '0);

endmodule : ivp_window_timer
`default_nettype wire

// [dv/test_ivp_top.sv]
// Self-checking bench for the interrupt vector placement block.
// Assumes the APB slave answers with pready and one register at offset zero.
`timescale 1ns/100ps
`default_nettype none
module test_ivp_top;
  localparam logic [11:0] B1 = 12'hE00;
  localparam logic [11:0] B2 = 12'hF00;
  localparam logic [11:0] B3 = 12'hF80;
  localparam logic [11:0] RA = ivp_pkg::MCU_CONTROL_OFFSET;
  logic        clk, srst, psel, penable, pwrite, pready, pslverr;
  logic        boot_rst, app_lock, boot_lock, retire, gie, blocked, irq_en;
  logic [11:0] paddr, pc, vec_base, vec_addr, rst_addr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0]  size_f;
  logic [4:0]  irq_num;
  logic [2:0]  spare;
  logic [3:0]  pstrb;
  logic        e;
  int          err_total;
  int          compares;

  ivp_top #(.BOOT_START_1(B1), .BOOT_START_2(B2), .BOOT_START_3(B3)) ivp_top_i (
    .CLK_I(clk), .SRST_I(srst), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(pstrb),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .BOOT_SIZE_FUSES_I(size_f), .BOOT_RESET_PROG_I(boot_rst),
    .APP_LOCK_PROG_I(app_lock), .BOOT_LOCK_PROG_I(boot_lock), .PC_I(pc),
    .INSN_RETIRE_I(retire), .GIE_I(gie), .IRQ_NUM_I(irq_num),
    .VECTOR_BASE_O(vec_base), .VECTOR_ADDR_O(vec_addr), .RESET_ADDR_O(rst_addr),
    .SPARE_CTRL_O(spare), .IRQ_BLOCK_O(blocked), .IRQ_ENABLE_O(irq_en));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // The access phase is held until pready is seen high, however long that takes.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic er);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] v);
    logic [31:0] d;
    apb(1'b1, RA, {24'h000000, v}, d, e);
  endtask : wr

  task automatic t_reset();
    apb(1'b0, RA, 32'h00000000, rd, e);
    chk("reg reset", 32'h00000000, rd);
    chk("pready", 32'h00000001, pready);
    chk("no slverr", 32'h00000000, e);
    chk("base", 32'h00000000, vec_base);
    chk("reset addr", 32'h00000000, rst_addr);
    $display("test reset done");
  endtask : t_reset

  task automatic t_unmapped();
    apb(1'b1, 12'h004, 32'h000000FF, rd, e);
    chk("slverr", 32'h00000001, e);
    apb(1'b0, 12'h004, 32'h00000000, rd, e);
    chk("unmapped read", 32'h00000000, rd);
    pstrb <= 4'hE;
    wr(8'h1C);
    pstrb <= 4'hF;
    apb(1'b0, RA, 32'h00000000, rd, e);
    chk("reg kept", 32'h00000000, rd);
    $display("test unmapped done");
  endtask : t_unmapped

  task automatic t_closed();
    wr(8'h1E);
    apb(1'b0, RA, 32'h00000000, rd, e);
    chk("closed write", 32'h0000001C, rd);
    chk("spare", 32'h00000007, spare);
    chk("base", 32'h00000000, vec_base);
    wr(8'h00);
    $display("test closed done");
  endtask : t_closed

  task automatic t_locks(input logic sel);
    @(posedge clk);
    app_lock <= sel;
    boot_lock <= !sel;
    pc <= sel ? 12'h100 : 12'hC10;
    #1 chk("lock block", 32'h00000001, blocked);
    chk("lock enable", 32'h00000000, irq_en);
    @(posedge clk);
    pc <= sel ? 12'hC10 : 12'h100;
    #1 chk("lock free", 32'h00000000, blocked);
    @(posedge clk);
    app_lock <= 1'b0;
    boot_lock <= 1'b0;
    $display("test locks done");
  endtask : t_locks

  task automatic t_change();
    wr(8'h01);
    #1 chk("enable block", 32'h00000001, blocked);
    chk("enable gate", 32'h00000000, irq_en);
    wr(8'h02);
    #1 chk("moved base", {20'h00000, ivp_pkg::BOOT_START_2K}, vec_base);
    apb(1'b0, RA, 32'h00000000, rd, e);
    chk("enable cleared", 32'h00000002, rd);
    #1 chk("held block", 32'h00000001, blocked);
    @(posedge clk);
    retire <= 1'b1;
    @(posedge clk);
    retire <= 1'b0;
    #1 chk("block lifted", 32'h00000000, blocked);
    chk("gie kept", 32'h00000001, irq_en);
    @(posedge clk);
    gie <= 1'b0;
    #1 chk("gie low", 32'h00000000, irq_en);
    chk("gie no block", 32'h00000000, blocked);
    @(posedge clk);
    gie <= 1'b1;
    $display("test change done");
  endtask : t_change

  task automatic t_vectors();
    logic [11:0] st [4];
    st = '{ivp_pkg::BOOT_START_2K, B1, B2, B3};
    @(posedge clk);
    irq_num <= 5'h01;
    boot_rst <= 1'b1;
    @(posedge clk);
    #1 chk("first vector", 32'h00000C01, vec_addr);
    chk("boot reset", 32'h00000C00, rst_addr);
    @(posedge clk);
    irq_num <= 5'h1F;
    @(posedge clk);
    #1 chk("last vector", 32'h00000C1F, vec_addr);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      size_f <= 2'(i);
      #1 chk("fuse base", {20'h00000, st[i]}, vec_base);
    end
    @(posedge clk);
    size_f <= 2'h0;
    $display("test vectors done");
  endtask : t_vectors

  task automatic t_lapse();
    wr(8'h01);
    repeat (3) @(posedge clk);
    #1 chk("window block", 32'h00000001, blocked);
    @(posedge clk);
    #1 chk("window lapsed", 32'h00000000, blocked);
    wr(8'h00);
    apb(1'b0, RA, 32'h00000000, rd, e);
    chk("late select", 32'h00000002, rd);
    chk("base kept", 32'h00000C00, vec_base);
    $display("test lapse done");
  endtask : t_lapse

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude

  initial begin
    #(25.0 * 3000);
    err_total++;
    conclude();
  end

  initial begin
    {srst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 47'h0};
    {size_f, boot_rst, app_lock, boot_lock, pc, retire, irq_num} = 23'h0;
    gie = 1'b1;
    pstrb = 4'hF;
    err_total = 0;
    compares = 0;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_unmapped();
    t_closed();
    t_locks(1'b0);
    t_change();
    t_vectors();
    t_locks(1'b1);
    t_lapse();
    conclude();
  end
endmodule : test_ivp_top
`default_nettype wire
